// [common/tdx_pkg.sv]
// package: register map, field layouts, timing counts for the des/xtea cipher engine
package tdx_pkg;

   // data path widths and input buffer depth
   localparam int unsigned TDX_WORD_W     = 32;
   localparam int unsigned TDX_FIFO_DEPTH = 16;

   // register byte offsets on the apb bus
   localparam logic [11:0] TDX_OFF_CTRL   = 12'h000;
   localparam logic [11:0] TDX_OFF_MODE   = 12'h004;
   localparam logic [11:0] TDX_OFF_IEN    = 12'h010;
   localparam logic [11:0] TDX_OFF_STATUS = 12'h01C;
   localparam logic [11:0] TDX_OFF_KEY0   = 12'h020;
   localparam logic [11:0] TDX_OFF_KEY5   = 12'h034;
   localparam logic [11:0] TDX_OFF_DIN0   = 12'h040;
   localparam logic [11:0] TDX_OFF_DIN1   = 12'h044;
   localparam logic [11:0] TDX_OFF_IV0    = 12'h048;
   localparam logic [11:0] TDX_OFF_IV1    = 12'h04C;
   localparam logic [11:0] TDX_OFF_DOUT0  = 12'h050;
   localparam logic [11:0] TDX_OFF_DOUT1  = 12'h054;

   // control register bit positions
   localparam int unsigned TDX_CTRL_START = 0;
   localparam int unsigned TDX_CTRL_SWRST = 1;

   // status register bit positions
   localparam int unsigned TDX_STAT_DATRDY = 0;
   localparam int unsigned TDX_STAT_BUSY   = 1;

   // algorithm field codes
   localparam logic [1:0] TDX_ALG_DES  = 2'h0;
   localparam logic [1:0] TDX_ALG_TDES = 2'h1;
   localparam logic [1:0] TDX_ALG_XTEA = 2'h2;

   // chaining field codes
   localparam logic [2:0] TDX_CH_ECB = 3'h0;
   localparam logic [2:0] TDX_CH_CBC = 3'h1;
   localparam logic [2:0] TDX_CH_OFB = 3'h2;
   localparam logic [2:0] TDX_CH_CFB = 3'h3;

   // cfb segment size codes
   localparam logic [1:0] TDX_CFB_64 = 2'h0;
   localparam logic [1:0] TDX_CFB_32 = 2'h1;
   localparam logic [1:0] TDX_CFB_16 = 2'h2;
   localparam logic [1:0] TDX_CFB_8  = 2'h3;

   // cycle budget: one load cycle, the rounds, one finish cycle
   localparam int unsigned TDX_DES_ROUNDS  = 16;
   localparam int unsigned TDX_DES_CYCLES  = 18;
   localparam int unsigned TDX_TDES_CYCLES = 50;
   localparam logic [6:0]  TDX_DES_LAST    = 7'(TDX_DES_CYCLES - 1);
   localparam logic [6:0]  TDX_TDES_LAST   = 7'(TDX_TDES_CYCLES - 1);
   localparam logic [31:0] TDX_XTEA_DELTA  = 32'h9E3779B9;

   // mode register layout
   typedef struct packed {
      logic [13:0] rsv;
      logic [5:0]  xtea_rounds_m1;
      logic        dma_en;
      logic        last_out;
      logic [1:0]  cfb_size;
      logic [2:0]  chain;
      logic        two_key;
      logic [1:0]  algo;
      logic        auto_start;
      logic        encrypt;
   } tdx_mode_s;

   localparam logic [31:0] TDX_MODE_RESET = 32'h0001F001;

   // sequencer states
   typedef enum logic [2:0] {
      TDX_IDLE,
      TDX_FETCH_HI,
      TDX_RUN,
      TDX_OUT_LO,
      TDX_OUT_HI
   } tdx_state_e;

endpackage

// [rtl/tdx_fifo.sv]
// input word buffer with valid/ready on both sides
`timescale 1ns/1ps
module tdx_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             wr_valid,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic                  wr_ready,
   output logic                  rd_valid,
   output logic [WIDTH-1:0]      rd_data,
   input  wire logic             rd_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0]   count;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic          not_full;
      logic          not_empty;
   } tdx_fifo_state_s;

   tdx_fifo_state_s       st_reg;
   tdx_fifo_state_s       st_next;
   logic [WIDTH-1:0]      mem [DEPTH];
   logic                  push;
   logic                  pop;

   assign push     = wr_valid && st_reg.not_full;
   assign pop      = rd_ready && st_reg.not_empty;
   assign wr_ready = st_reg.not_full;
   assign rd_valid = st_reg.not_empty;
   assign rd_data  = mem[st_reg.rptr];

   // pointer and level update, flags precomputed so ports come from flops
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wptr = st_reg.wptr + 1'b1;
      end
      if (pop) begin
         st_next.rptr = st_reg.rptr + 1'b1;
      end
      st_next.count     = st_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
      st_next.not_full  = (st_next.count != (AW + 1)'(DEPTH));
      st_next.not_empty = (st_next.count != '0);
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{count: '0, wptr: '0, rptr: '0, not_full: 1'b1, not_empty: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // storage array, no reset needed
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[st_reg.wptr] <= wr_data;
      end
   end
endmodule

// [rtl/tdx_cipher.sv]
// des / triple des / xtea block cipher engine with apb registers and stream ports
// Function
// - ecb, cbc, ofb, cfb chaining selectable
// - three 64-bit keys in word pairs
// - input block and iv in word pairs
// - load then process, result in output words
// - single des uses one key
// - single des block takes 18 cycles
// - triple des block takes 50 cycles
// - triple des with two or three keys
// - xtea 128-bit key, rounds up to 64
// - cfb segment of 8/16/32/64 bits
// - last-output mode exposes only final result
// - stream handshakes for input and output
// - one interrupt output
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module tdx_cipher (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        in_valid,
   input  wire logic [31:0] in_data,
   output logic             in_ready,
   output logic             out_valid,
   output logic [31:0]      out_data,
   input  wire logic        out_ready
);
   // whole module state
   typedef struct packed {
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
      tdx_pkg::tdx_mode_s   mode;
      logic                 ien;
      logic                 datrdy;
      logic                 irq;
      logic [5:0][31:0]     key;
      logic [1:0][31:0]     din;
      logic [63:0]          iv;
      logic [63:0]          dout;
      logic [63:0]          blk;
      logic [31:0]          sum;
      logic [6:0]           cnt;
      logic                 out_valid;
      logic [31:0]          out_data;
      tdx_pkg::tdx_state_e  st;
   } tdx_state_s;

   tdx_state_s   r_reg;
   tdx_state_s   r_next;
   logic         fifo_valid;
   logic [31:0]  fifo_data;
   logic         fifo_pop;

   // keyed feistel mixing of one half block
   function automatic logic [31:0] tdx_mix(input logic [31:0] r, input logic [31:0] k);
      logic [31:0] t;
      t = r ^ k;
      return {t[26:0], t[31:27]} ^ (t + {t[15:0], t[31:16]});
   endfunction

   // round subkey from a 64-bit key and round index
   function automatic logic [31:0] tdx_subkey(input logic [63:0] k, input logic [3:0] idx);
      logic [63:0] t;
      t = {k[63:32], k[63:32]} << idx;
      return k[31:0] ^ t[63:32];
   endfunction

   // xtea half-round mixing term
   function automatic logic [31:0] tdx_xmix(input logic [31:0] v);
      return ((v << 4) ^ (v >> 5)) + v;
   endfunction

   // input stream buffer
   tdx_fifo #(
      .WIDTH (tdx_pkg::TDX_WORD_W),
      .DEPTH (tdx_pkg::TDX_FIFO_DEPTH)
   ) u_in_fifo (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_valid (in_valid),
      .wr_data  (in_data),
      .wr_ready (in_ready),
      .rd_valid (fifo_valid),
      .rd_data  (fifo_data),
      .rd_ready (fifo_pop)
   );

   // engine pulls words only while waiting for a block
   assign fifo_pop = r_reg.mode.dma_en && fifo_valid &&
                     (r_reg.st == tdx_pkg::TDX_IDLE || r_reg.st == tdx_pkg::TDX_FETCH_HI);

   // next-state logic: bus slave, sequencer, cipher rounds, chaining
   always_comb begin
      logic        acc;
      logic        wr;
      logic        idle;
      logic        start;
      logic        core_enc;
      logic [6:0]  last;
      logic [6:0]  rnd;
      logic [1:0]  stage;
      logic [3:0]  sub;
      logic        stage_dec;
      logic [1:0]  kidx;
      logic [63:0] key64;
      logic [31:0] fv;
      logic [63:0] din64;
      logic [63:0] core;
      logic [63:0] mask;
      logic [63:0] seg;
      logic [6:0]  sbits;
      logic [31:0] xk0;
      logic [31:0] xk1;
      logic [31:0] v0;
      logic [31:0] v1;
      logic [31:0] s1;
      logic        mapped;
      logic [31:0] rd;
      acc       = 1'b0;
      wr        = 1'b0;
      idle      = 1'b0;
      start     = 1'b0;
      core_enc  = 1'b0;
      last      = '0;
      rnd       = '0;
      stage     = '0;
      sub       = '0;
      stage_dec = 1'b0;
      kidx      = '0;
      key64     = '0;
      fv        = '0;
      din64     = '0;
      core      = '0;
      mask      = '0;
      seg       = '0;
      sbits     = '0;
      xk0       = '0;
      xk1       = '0;
      v0        = '0;
      v1        = '0;
      s1        = '0;
      mapped    = 1'b0;
      rd        = '0;
      r_next    = r_reg;

      // apb: one wait state, effect at the edge where pready is seen high
      acc  = psel && penable && r_reg.pready;
      wr   = acc && pwrite;
      idle = (r_reg.st == tdx_pkg::TDX_IDLE);
      r_next.pready = psel && penable && !r_reg.pready;
      mapped = (paddr == tdx_pkg::TDX_OFF_CTRL) || (paddr == tdx_pkg::TDX_OFF_MODE) ||
               (paddr == tdx_pkg::TDX_OFF_IEN) || (paddr == tdx_pkg::TDX_OFF_STATUS) ||
               (paddr >= tdx_pkg::TDX_OFF_KEY0 && paddr <= tdx_pkg::TDX_OFF_KEY5 &&
                paddr[1:0] == 2'h0) ||
               (paddr >= tdx_pkg::TDX_OFF_DIN0 && paddr <= tdx_pkg::TDX_OFF_DOUT1 &&
                paddr[1:0] == 2'h0);
      case (paddr)
         tdx_pkg::TDX_OFF_MODE:   rd = r_reg.mode;
         tdx_pkg::TDX_OFF_IEN:    rd = {31'h0, r_reg.ien};
         tdx_pkg::TDX_OFF_STATUS: rd = {30'h0, !idle, r_reg.datrdy};
         tdx_pkg::TDX_OFF_DOUT0:  rd = r_reg.dout[63:32];
         tdx_pkg::TDX_OFF_DOUT1:  rd = r_reg.dout[31:0];
         default:                 rd = 32'h0; // write-only words read as zero
      endcase
      r_next.prdata  = (r_next.pready && !pwrite) ? rd : 32'h0;
      r_next.pslverr = r_next.pready && !mapped;

      // register writes; key, iv, data and mode locked while a block runs
      if (wr && mapped && idle) begin
         case (paddr)
            tdx_pkg::TDX_OFF_MODE: r_next.mode = pwdata;
            tdx_pkg::TDX_OFF_DIN0: r_next.din[0] = pwdata;
            tdx_pkg::TDX_OFF_DIN1: begin
               r_next.din[1] = pwdata;
               start = r_reg.mode.auto_start;
            end
            tdx_pkg::TDX_OFF_IV0:  r_next.iv[63:32] = pwdata;
            tdx_pkg::TDX_OFF_IV1:  r_next.iv[31:0] = pwdata;
            tdx_pkg::TDX_OFF_CTRL: start = pwdata[tdx_pkg::TDX_CTRL_START];
            default: begin
               if (paddr >= tdx_pkg::TDX_OFF_KEY0 && paddr <= tdx_pkg::TDX_OFF_KEY5) begin
                  r_next.key[3'(paddr[4:2])] = pwdata;
               end
            end
         endcase
      end
      if (wr && paddr == tdx_pkg::TDX_OFF_IEN) begin
         r_next.ien = pwdata[0];
      end

      // output read clears data ready; a set below wins
      if (acc && !pwrite && paddr == tdx_pkg::TDX_OFF_DOUT1) begin
         r_next.datrdy = 1'b0;
      end

      // cipher direction and block length
      core_enc = r_reg.mode.encrypt || r_reg.mode.chain == tdx_pkg::TDX_CH_OFB ||
                 r_reg.mode.chain == tdx_pkg::TDX_CH_CFB;
      case (r_reg.mode.algo)
         tdx_pkg::TDX_ALG_TDES: last = tdx_pkg::TDX_TDES_LAST;
         tdx_pkg::TDX_ALG_XTEA: last = 7'(r_reg.mode.xtea_rounds_m1) + 7'h2;
         default:               last = tdx_pkg::TDX_DES_LAST;
      endcase
      din64 = {r_reg.din[0], r_reg.din[1]};

      // des/tdes round bookkeeping
      rnd   = r_reg.cnt - 7'h1;
      stage = rnd[5:4];
      sub   = rnd[3:0];
      if (r_reg.mode.algo == tdx_pkg::TDX_ALG_TDES) begin
         stage_dec = core_enc ? (stage == 2'h1) : (stage != 2'h1);
         kidx      = core_enc ? stage : 2'h2 - stage;
         if (r_reg.mode.two_key && kidx == 2'h2) begin
            kidx = 2'h0;
         end
      end else begin
         stage_dec = !core_enc;
         kidx      = 2'h0;
      end
      key64 = {r_reg.key[{kidx, 1'b0}], r_reg.key[{kidx, 1'b1}]};
      fv    = tdx_mix(r_reg.blk[31:0], tdx_subkey(key64, stage_dec ? 4'hF - sub : sub));

      // xtea key words from the first two 64-bit keys
      v0  = r_reg.blk[63:32];
      v1  = r_reg.blk[31:0];
      xk0 = r_reg.key[r_reg.sum[1:0]];
      s1  = r_reg.sum + tdx_pkg::TDX_XTEA_DELTA;

      // cfb segment mask and width
      case (r_reg.mode.cfb_size)
         tdx_pkg::TDX_CFB_32: sbits = 7'd32;
         tdx_pkg::TDX_CFB_16: sbits = 7'd16;
         tdx_pkg::TDX_CFB_8:  sbits = 7'd8;
         default:             sbits = 7'd64;
      endcase
      mask = ~(64'hFFFFFFFFFFFFFFFF >> sbits);

      // sequencer
      case (r_reg.st)
         tdx_pkg::TDX_IDLE: begin
            if (fifo_pop) begin
               r_next.din[0] = fifo_data;
               r_next.st     = tdx_pkg::TDX_FETCH_HI;
            end else if (start) begin
               r_next.cnt = 7'h0;
               r_next.st  = tdx_pkg::TDX_RUN;
            end
         end
         tdx_pkg::TDX_FETCH_HI: begin
            if (fifo_pop) begin
               r_next.din[1] = fifo_data;
               r_next.cnt    = 7'h0;
               r_next.st     = tdx_pkg::TDX_RUN;
            end
         end
         tdx_pkg::TDX_RUN: begin
            r_next.cnt = r_reg.cnt + 7'h1;
            if (r_reg.cnt == 7'h0) begin
               // load cycle: pick the cipher input for the chaining mode
               case (r_reg.mode.chain)
                  tdx_pkg::TDX_CH_CBC: r_next.blk = r_reg.mode.encrypt ? din64 ^ r_reg.iv
                                                                       : din64;
                  tdx_pkg::TDX_CH_OFB: r_next.blk = r_reg.iv;
                  tdx_pkg::TDX_CH_CFB: r_next.blk = r_reg.iv;
                  default:             r_next.blk = din64;
               endcase
               r_next.sum = core_enc ? 32'h0 : 32'(tdx_pkg::TDX_XTEA_DELTA *
                                                   (32'(r_reg.mode.xtea_rounds_m1) + 32'h1));
            end else if (r_reg.cnt != last) begin
               if (r_reg.mode.algo == tdx_pkg::TDX_ALG_XTEA) begin
                  // one full xtea cycle per clock
                  if (core_enc) begin
                     v0  = v0 + (tdx_xmix(v1) ^ (r_reg.sum + xk0));
                     xk1 = r_reg.key[s1[12:11]];
                     v1  = v1 + (tdx_xmix(v0) ^ (s1 + xk1));
                     r_next.sum = s1;
                  end else begin
                     xk1 = r_reg.key[r_reg.sum[12:11]];
                     v1  = v1 - (tdx_xmix(v0) ^ (r_reg.sum + xk1));
                     s1  = r_reg.sum - tdx_pkg::TDX_XTEA_DELTA;
                     xk0 = r_reg.key[s1[1:0]];
                     v0  = v0 - (tdx_xmix(v1) ^ (s1 + xk0));
                     r_next.sum = s1;
                  end
                  r_next.blk = {v0, v1};
               end else if (sub == 4'hF) begin
                  r_next.blk = {r_reg.blk[63:32] ^ fv, r_reg.blk[31:0]};
               end else begin
                  r_next.blk = {r_reg.blk[31:0], r_reg.blk[63:32] ^ fv};
               end
            end else begin
               // finish cycle: chain the cipher output
               core = r_reg.blk;
               case (r_reg.mode.chain)
                  tdx_pkg::TDX_CH_CBC: begin
                     r_next.dout = r_reg.mode.encrypt ? core : core ^ r_reg.iv;
                     r_next.iv   = r_reg.mode.encrypt ? core : din64;
                  end
                  tdx_pkg::TDX_CH_OFB: begin
                     r_next.dout = core ^ din64;
                     r_next.iv   = core;
                  end
                  tdx_pkg::TDX_CH_CFB: begin
                     r_next.dout = (din64 ^ core) & mask;
                     seg         = r_reg.mode.encrypt ? (din64 ^ core) & mask : din64 & mask;
                     r_next.iv   = (r_reg.iv << sbits) | (seg >> (7'd64 - sbits));
                  end
                  default: r_next.dout = core;
               endcase
               r_next.st = tdx_pkg::TDX_IDLE;
               if (!r_reg.mode.last_out) begin
                  r_next.datrdy = 1'b1;
                  if (r_reg.mode.dma_en) begin
                     r_next.out_valid = 1'b1;
                     r_next.out_data  = r_next.dout[63:32];
                     r_next.st        = tdx_pkg::TDX_OUT_LO;
                  end
               end
            end
         end
         tdx_pkg::TDX_OUT_LO: begin
            if (out_ready) begin
               r_next.out_data = r_reg.dout[31:0];
               r_next.st       = tdx_pkg::TDX_OUT_HI;
            end
         end
         tdx_pkg::TDX_OUT_HI: begin
            if (out_ready) begin
               r_next.out_valid = 1'b0;
               r_next.out_data  = 32'h0;
               r_next.st        = tdx_pkg::TDX_IDLE;
            end
         end
         default: r_next.st = tdx_pkg::TDX_IDLE;
      endcase

      // software reset of the sequencer and flag
      if (wr && paddr == tdx_pkg::TDX_OFF_CTRL && pwdata[tdx_pkg::TDX_CTRL_SWRST]) begin
         r_next.st        = tdx_pkg::TDX_IDLE;
         r_next.datrdy    = 1'b0;
         r_next.out_valid = 1'b0;
         r_next.out_data  = 32'h0;
      end

      r_next.irq = r_next.datrdy && r_next.ien;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg      <= '0;
         r_reg.mode <= tdx_pkg::TDX_MODE_RESET;
         r_reg.st   <= tdx_pkg::TDX_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign pready    = r_reg.pready;
   assign prdata    = r_reg.prdata;
   assign pslverr   = r_reg.pslverr;
   assign irq       = r_reg.irq;
   assign out_valid = r_reg.out_valid;
   assign out_data  = r_reg.out_data;
endmodule

// [dv/tdx_cipher_props.sv]
// checker: bus, stream and latency properties
`timescale 1ns/1ps
module tdx_cipher_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        out_valid,
   input wire logic [31:0] out_data,
   input wire logic        out_ready
);
   logic [31:0] mode_q;
   logic        ien_q;
   logic        wr_ok;
   logic        go;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed write, and a start that should raise the interrupt
   assign wr_ok = pready && pwrite && !pslverr;
   assign go = wr_ok && paddr == tdx_pkg::TDX_OFF_CTRL && pwdata[0] && ien_q && !mode_q[10];
   // bus-written mode and irq enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= tdx_pkg::TDX_MODE_RESET;
         ien_q  <= 1'b0;
      end else begin
         if (wr_ok && paddr == tdx_pkg::TDX_OFF_MODE) mode_q <= pwdata;
         if (wr_ok && paddr == tdx_pkg::TDX_OFF_IEN) ien_q <= pwdata[0];
      end
   end
   chk_apb_wait: assert property ((psel && !penable) |=> !pready ##1 pready)
      else $error("no single wait state");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("ready held");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero");
   chk_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
      12'h010, 12'h01C, [12'h020:12'h034], [12'h040:12'h054]}))
      else $error("error response wrong");
   chk_des_time: assert property ((go && mode_q[3:2] == 2'h0) |-> ##19 $rose(irq))
      else $error("des latency");
   chk_tdes_time: assert property ((go && mode_q[3:2] == 2'h1) |-> ##51 $rose(irq))
      else $error("tdes latency");
   chk_xtea_time: assert property ((go && mode_q[3:2] == 2'h2 && mode_q[17:12] == 6'h1F)
      |-> ##35 $rose(irq))
      else $error("xtea latency");
   chk_irq_clear: assert property ((pready && !pwrite && paddr == 12'h054 && irq) |=> !irq)
      else $error("irq not cleared");
   chk_last_quiet: assert property (mode_q[10] |-> !$rose(irq))
      else $error("irq in last mode");
   chk_out_hold: assert property ((out_valid && !out_ready) |=> out_valid && $stable(out_data))
      else $error("output not held");
endmodule

bind tdx_cipher tdx_cipher_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .irq(irq), .out_valid(out_valid),
   .out_data(out_data), .out_ready(out_ready));

// [dv/tdx_sink_model.sv]
// output stream sink in place of the dma channel
`timescale 1ns/1ps
module tdx_sink_model (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        out_valid,
   input wire logic [31:0] out_data,
   input wire logic        stall,
   input wire logic        slow,
   output logic            out_ready,
   output logic [31:0]     got_cnt,
   output logic [63:0]     got_first
);
   // ready dropped while stalled, every other cycle when slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ready <= 1'b0;
         got_cnt   <= 32'h0;
         got_first <= 64'h0;
      end else begin
         out_ready <= !stall && !(slow && out_ready);
         if (out_valid && out_ready) begin
            got_cnt <= got_cnt + 32'h1;
            if (got_cnt < 32'h2) got_first <= {got_first[31:0], out_data};
         end
      end
   end
endmodule

// [dv/tdx_cipher_tb.sv]
// testbench for the cipher engine
`timescale 1ns/1ps
module tdx_cipher_tb;
   localparam logic [63:0] PT = 64'h0123456789ABCDEF;
   localparam logic [63:0] IV = 64'hFEDCBA9876543210;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        in_valid = 1'b0, stall = 1'b1, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, in_data = 32'h0;
   logic        pready, pslverr, irq, in_ready, out_valid, out_ready, er;
   logic [31:0] prdata, out_data, got_cnt, rd;
   logic [63:0] got_first, ct, ec, eb;
   int          failures = 0, checked = 0, cycles = 0, n;
   // 50 mhz clock
   always #10 pclk = ~pclk;
   tdx_cipher dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .irq(irq), .in_valid(in_valid), .in_data(in_data),
      .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
   tdx_sink_model sink (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
      .out_data(out_data), .stall(stall), .slow(slow), .out_ready(out_ready),
      .got_cnt(got_cnt), .got_first(got_first));
   // cycle ceiling against a hung run
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("counts: %0d checked, %0d failures", checked, failures);
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // mode word, 32 xtea rounds; default ecb encrypt
   function automatic logic [31:0] md(logic [1:0] al, logic [2:0] ch = 3'h0,
                                      logic [1:0] cs = 2'h0, logic e = 1'b1);
      md = {14'h0, 6'h1F, 2'h0, cs, ch, 1'b0, al, 1'b0, e};
   endfunction
   task automatic wiv();
      apb(1'b1, tdx_pkg::TDX_OFF_IV0, IV[63:32]);
      apb(1'b1, tdx_pkg::TDX_OFF_IV1, IV[31:0]);
   endtask
   // run one block, time it by irq, read result
   task automatic blk(input logic [31:0] m, input logic [63:0] p, input int c);
      apb(1'b1, tdx_pkg::TDX_OFF_MODE, m);
      apb(1'b1, tdx_pkg::TDX_OFF_DIN0, p[63:32]);
      apb(1'b1, tdx_pkg::TDX_OFF_DIN1, p[31:0]);
      apb(1'b1, tdx_pkg::TDX_OFF_CTRL, 32'h1);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (irq !== 1'b1 && n < 100);
      apb(1'b0, tdx_pkg::TDX_OFF_STATUS);
      if (c > 0) chk("latency", 64'(c), 64'(n));
      if (c > 0) chk("datrdy", 64'h1, 64'(rd));
      apb(1'b0, tdx_pkg::TDX_OFF_DOUT0);
      ct[63:32] = rd;
      apb(1'b0, tdx_pkg::TDX_OFF_DOUT1);
      ct[31:0] = rd;
      #1;
   endtask
   task automatic t_regs();
      apb(1'b0, tdx_pkg::TDX_OFF_MODE);
      chk("mode reset", 64'(tdx_pkg::TDX_MODE_RESET), 64'(rd));
      apb(1'b0, 12'h0F0);
      chk("unmapped error", 64'h1, 64'(er));
      for (int i = 0; i < 6; i++) apb(1'b1, 12'(32'h20 + 4 * i), 32'h13579BDF + 32'h11111111 * i);
      apb(1'b0, tdx_pkg::TDX_OFF_KEY0);
      chk("key write only", 64'h0, 64'(rd));
      apb(1'b1, tdx_pkg::TDX_OFF_IEN, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_ciphers();
      blk(md(2'h0), PT, 18);
      chk("irq cleared", 64'h0, 64'(irq));
      blk(md(2'h0, 3'h0, 2'h0, 1'b0), ct, 18);
      chk("des inverse", PT, ct);
      blk(md(2'h1), PT, 50);
      ec = ct;
      blk(md(2'h1) | 32'h10, PT, 50);
      chk("two key differs", 64'h1, 64'(ct != ec));
      blk(md(2'h1, 3'h0, 2'h0, 1'b0), ec, 50);
      chk("tdes inverse", PT, ct);
      blk(md(2'h2), PT, 34);
      blk(md(2'h2, 3'h0, 2'h0, 1'b0), ct, 34);
      chk("xtea inverse", PT, ct);
      blk(md(2'h2) | 32'h3F000, PT, 66);
      $display("test ciphers done");
   endtask
   task automatic t_chain();
      blk(md(2'h0), PT ^ IV, 18);
      eb = ct;
      wiv();
      blk(md(2'h0, 3'h1), PT, 18);
      chk("cbc", eb, ct);
      blk(md(2'h0), IV, 18);
      ec = ct;
      wiv();
      blk(md(2'h0, 3'h2), PT, 18);
      chk("ofb", ec ^ PT, ct);
      for (int i = 0; i < 4; i++) begin
         wiv();
         blk(md(2'h0, 3'h3, 2'(i)), PT, 18);
         chk("cfb", (ec ^ PT) & ~(~64'h0 >> (64 >> i)), ct);
      end
      wiv();
      blk(md(2'h0, 3'h1) | 32'h400, PT, 0);
      chk("last no irq", 64'h0, 64'(irq));
      chk("last result", eb, ct);
      apb(1'b0, tdx_pkg::TDX_OFF_STATUS);
      chk("last status", 64'h0, 64'(rd));
      $display("test chain done");
   endtask
   task automatic t_stream();
      blk(md(2'h0), 64'h1, 18);
      apb(1'b1, tdx_pkg::TDX_OFF_MODE, md(2'h0) | 32'h800);
      n = 0;
      in_valid <= 1'b1;
      do begin
         @(posedge pclk);
         if (in_ready === 1'b1) n++;
         in_data <= 32'(n);
      end while (in_ready !== 1'b0 && n < 40);
      in_valid <= 1'b0;
      chk("fifo refuses", 64'h1, 64'(n < 40));
      stall <= 1'b0;
      slow <= 1'b1;
      for (int i = 0; i < 2000 && got_cnt !== 32'(n & ~1); i++) @(posedge pclk);
      #1;
      chk("words drained", 64'(n & ~1), 64'(got_cnt));
      chk("first block", ct, got_first);
      chk("ready again", 64'h1, 64'(in_ready));
      $display("test stream done");
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ciphers();
      t_chain();
      t_stream();
      stop_test();
   end
endmodule
